// File: phy_status_cfg.svh
`ifndef PHY_STATUS_CFG_SVH
`define PHY_STATUS_CFG_SVH

// Register indexes; the byte address is four times the index
`define IDX_COMBINED_STATUS 8'h10
`define IDX_FALSE_CARRIER 8'h14
`define IDX_RECEIVE_ERROR 8'h15
`define IDX_INT_STATUS 8'h18
`define IDX_INT_MASK 8'h19

// Combined status bit positions
`define BIT_LINK 0
`define BIT_SPEED10 1
`define BIT_DUPLEX 2
`define BIT_LOOPBACK 3
`define BIT_NEG_DONE 4
`define BIT_JABBER 5
`define BIT_FC_LATCH 11
`define BIT_RXERR_LATCH 13

// Counter field
`define COUNT_WIDTH 8
`define COUNT_MAX 8'hFF
`define COUNT_RESET 8'h00

// Interrupt status bit positions and width
`define INT_WIDTH 4
`define INT_FALSE_CARRIER 0
`define INT_RECEIVE_ERROR 1
`define INT_LINK_CHANGE 2
`define INT_NEG_DONE 3
`define INT_RESET 4'h0

`endif

// File: phy_status_pkg.sv
package phy_status_pkg;

   // Progress of one carrier event for receive error qualification
   typedef enum logic [3:0] {
      carrier_idle = 4'b0001,
      carrier_clean = 4'b0010,
      carrier_errored = 4'b0100,
      carrier_collided = 4'b1000
   } carrier_state_type;

   typedef logic [7:0] reg_index_type;

endpackage

// File: phy_status_regs.sv
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "phy_status_cfg.svh"


module phy_status_regs
   import phy_status_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Status sources from the transceiver core
   input wire logic jabber_detect,
   input wire logic negotiation_done_flag,
   input wire logic loopback_enabled,
   input wire logic full_duplex,
   input wire logic speed_10,
   input wire logic link_valid,
   // Receive datapath events
   input wire logic false_carrier_event,
   input wire logic carrier_valid,
   input wire logic invalid_symbol,
   input wire logic collision,
   // Interrupt
   output logic irq
);

   //--------------------------------------------------------------
   // Bus decode
   //--------------------------------------------------------------

   logic addr_phase;
   logic rd_take;
   logic wr_take;
   reg_index_type addr_idx;
   logic wr_pending;
   reg_index_type wr_idx;
   logic rd_false_carrier;
   logic rd_receive_error;

   // Valid transfer to this slave; only NONSEQ and SEQ carry one
   assign addr_phase = hsel && hready && htrans[1];
   assign rd_take = addr_phase && !hwrite;
   assign wr_take = addr_phase && hwrite;
   assign addr_idx = haddr[9:2];

   // Read side effects fire when the read is accepted
   assign rd_false_carrier = rd_take && (addr_idx == `IDX_FALSE_CARRIER);
   assign rd_receive_error = rd_take && (addr_idx == `IDX_RECEIVE_ERROR);

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Write address held for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         wr_idx <= 8'h00;
      end else if (hready) begin
         wr_pending <= wr_take;
         wr_idx <= wr_take ? addr_idx : wr_idx;
      end
   end

   //--------------------------------------------------------------
   // Status sampling
   //--------------------------------------------------------------

   logic jabber;
   logic neg_done;
   logic loopback;
   logic duplex;
   logic speed10;
   logic link;

   // Registered mirrors; reads never write back into them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         jabber <= 1'b0;
         neg_done <= 1'b0;
         loopback <= 1'b0;
         duplex <= 1'b0;
         speed10 <= 1'b0;
         link <= 1'b0;
      end else begin
         jabber <= jabber_detect;
         neg_done <= negotiation_done_flag;
         loopback <= loopback_enabled;
         duplex <= full_duplex;
         speed10 <= speed_10;
         link <= link_valid;
      end
   end

   //--------------------------------------------------------------
   // Carrier event qualification
   //--------------------------------------------------------------

   carrier_state_type carrier_state;
   carrier_state_type next_carrier_state;
   logic rx_error_event;

   // Collision anywhere in the event vetoes it, so judge at carrier end
   always_comb begin
      next_carrier_state = carrier_state;
      case (carrier_state)
         carrier_idle: begin
            if (carrier_valid) begin
               if (collision) begin
                  next_carrier_state = carrier_collided;
               end else if (invalid_symbol) begin
                  next_carrier_state = carrier_errored;
               end else begin
                  next_carrier_state = carrier_clean;
               end
            end
         end
         carrier_clean: begin
            if (!carrier_valid) begin
               next_carrier_state = carrier_idle;
            end else if (collision) begin
               next_carrier_state = carrier_collided;
            end else if (invalid_symbol) begin
               next_carrier_state = carrier_errored;
            end
         end
         carrier_errored: begin
            if (!carrier_valid) begin
               next_carrier_state = carrier_idle;
            end else if (collision) begin
               next_carrier_state = carrier_collided;
            end
         end
         carrier_collided: begin
            if (!carrier_valid) begin
               next_carrier_state = carrier_idle;
            end
         end
         default: begin
            next_carrier_state = carrier_idle;
         end
      endcase
   end

   // Carrier tracker state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         carrier_state <= carrier_idle;
      end else begin
         carrier_state <= next_carrier_state;
      end
   end

   assign rx_error_event = (carrier_state == carrier_errored) &&
                           !carrier_valid;

   //--------------------------------------------------------------
   // Event counters
   //--------------------------------------------------------------

   logic [7:0] false_carrier_count;
   logic [7:0] symbol_error_count;

   sat_event_counter false_carrier_counter (
      .hclk(hclk),
      .hresetn(hresetn),
      .inc(false_carrier_event),
      .clr(rd_false_carrier),
      .count(false_carrier_count)
   );

   sat_event_counter receive_error_counter (
      .hclk(hclk),
      .hresetn(hresetn),
      .inc(rx_error_event),
      .clr(rd_receive_error),
      .count(symbol_error_count)
   );

   //--------------------------------------------------------------
   // Latched event flags
   //--------------------------------------------------------------

   logic fc_latch;
   logic rxerr_latch;

   // A new event in the read cycle keeps the flag set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fc_latch <= 1'b0;
         rxerr_latch <= 1'b0;
      end else begin
         if (false_carrier_event) begin
            fc_latch <= 1'b1;
         end else if (rd_false_carrier) begin
            fc_latch <= 1'b0;
         end
         if (rx_error_event) begin
            rxerr_latch <= 1'b1;
         end else if (rd_receive_error) begin
            rxerr_latch <= 1'b0;
         end
      end
   end

   //--------------------------------------------------------------
   // Interrupts
   //--------------------------------------------------------------

   logic [3:0] int_status;
   logic [3:0] int_mask;
   logic [3:0] int_events;
   logic [3:0] int_clear;
   logic link_prev;
   logic neg_done_prev;

   // Previous levels for edge events
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link_prev <= 1'b0;
         neg_done_prev <= 1'b0;
      end else begin
         link_prev <= link;
         neg_done_prev <= neg_done;
      end
   end

   assign int_events[`INT_FALSE_CARRIER] = false_carrier_event;
   assign int_events[`INT_RECEIVE_ERROR] = rx_error_event;
   assign int_events[`INT_LINK_CHANGE] = link ^ link_prev;
   assign int_events[`INT_NEG_DONE] = neg_done && !neg_done_prev;

   // Write one to clear, during the write data phase
   assign int_clear = (wr_pending && (wr_idx == `IDX_INT_STATUS)) ?
                      hwdata[3:0] : `INT_RESET;

   // Sticky bits; a set in the clearing cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_status <= `INT_RESET;
      end else begin
         int_status <= (int_status & ~int_clear) | int_events;
      end
   end

   // Mask register, one enables the source
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_mask <= `INT_RESET;
      end else if (wr_pending && (wr_idx == `IDX_INT_MASK)) begin
         int_mask <= hwdata[3:0];
      end
   end

   // Level output straight from flops, no glitch path
   assign irq = |(int_status & int_mask);

   //--------------------------------------------------------------
   // Read data
   //--------------------------------------------------------------

   logic [31:0] next_rdata;
   logic [31:0] status_word;

   // Upper status bits outside this block read as zero
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`BIT_LINK] = link;
      status_word[`BIT_SPEED10] = speed10;
      status_word[`BIT_DUPLEX] = duplex;
      status_word[`BIT_LOOPBACK] = loopback;
      status_word[`BIT_NEG_DONE] = neg_done;
      status_word[`BIT_JABBER] = jabber;
      status_word[`BIT_FC_LATCH] = fc_latch;
      status_word[`BIT_RXERR_LATCH] = rxerr_latch;
   end

   // Register select; counter upper bits and unmapped reads give zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (addr_idx == `IDX_COMBINED_STATUS) begin
         next_rdata = status_word;
      end else if (addr_idx == `IDX_FALSE_CARRIER) begin
         next_rdata = {24'h00_0000, false_carrier_count};
      end else if (addr_idx == `IDX_RECEIVE_ERROR) begin
         next_rdata = {24'h00_0000, symbol_error_count};
      end else if (addr_idx == `IDX_INT_STATUS) begin
         next_rdata = {28'h000_0000, int_status};
      end else if (addr_idx == `IDX_INT_MASK) begin
         next_rdata = {28'h000_0000, int_mask};
      end
   end

   // Captured at the address edge, so the value read is the one cleared
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata <= next_rdata;
      end
   end

   // hsize is accepted but only whole-word access is meaningful
   logic size_unused;
   assign size_unused = ^hsize;

endmodule // phy_status_regs

// File: phy_status_regs_checker.sv
`timescale 1ns/1ps

// ----------------------------------------
// Port checker for the status bank
// ----------------------------------------
module phy_status_regs_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic jabber_detect,
   input wire logic negotiation_done_flag,
   input wire logic loopback_enabled,
   input wire logic full_duplex,
   input wire logic speed_10,
   input wire logic link_valid,
   input wire logic false_carrier_event
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Accepted read; data shows one cycle later
   sequence rd_at(logic [31:0] a);
      hsel && hready && htrans[1] && !hwrite && haddr == a;
   endsequence

   // Mirrors are registered once, then captured by the read
   AST_LINK: assert property (rd_at(32'h40) |=>
      hrdata[0] == $past(link_valid, 2))
      else $error("link bit does not follow link input");
   AST_SPEED: assert property (rd_at(32'h40) |=>
      hrdata[1] == $past(speed_10, 2))
      else $error("speed bit does not follow speed input");
   AST_DUPLEX: assert property (rd_at(32'h40) |=>
      hrdata[2] == $past(full_duplex, 2))
      else $error("duplex bit does not follow duplex input");
   AST_LOOP: assert property (rd_at(32'h40) |=>
      hrdata[3] == $past(loopback_enabled, 2))
      else $error("loopback bit does not follow input");
   AST_NEG: assert property (rd_at(32'h40) |=>
      hrdata[4] == $past(negotiation_done_flag, 2))
      else $error("negotiation bit does not follow input");
   AST_JABBER: assert property (rd_at(32'h40) |=>
      hrdata[5] == $past(jabber_detect, 2))
      else $error("jabber bit does not follow input");
   // Upper counter bits stay zero whatever happens
   AST_CNT_UPPER: assert property (
      (rd_at(32'h50) or rd_at(32'h54)) |=> hrdata[31:8] == 24'h0)
      else $error("counter upper bits not zero");
   // Single transfers put two reads three cycles apart; no event from the first read on
   AST_FC_CLEAR: assert property (
      (rd_at(32'h50) ##0 !false_carrier_event [*3]) ##1 rd_at(32'h50)
      |=> hrdata[7:0] == 8'h00)
      else $error("false carrier count not cleared by read");
endmodule // phy_status_regs_checker

bind phy_status_regs phy_status_regs_checker i_chk (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .jabber_detect(jabber_detect), .loopback_enabled(loopback_enabled),
   .negotiation_done_flag(negotiation_done_flag), .speed_10(speed_10),
   .full_duplex(full_duplex), .link_valid(link_valid),
   .false_carrier_event(false_carrier_event));

// File: sat_event_counter.sv
`timescale 1ns/1ps
`include "phy_status_cfg.svh"

module sat_event_counter (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic inc,
   input wire logic clr,
   output logic [7:0] count
);

   logic [7:0] next_count;

   // Saturating next value; an event in the clearing cycle still counts
   always_comb begin
      if (clr) begin
         next_count = inc ? 8'h01 : `COUNT_RESET;
      end else if (inc && (count != `COUNT_MAX)) begin
         next_count = count + 8'h01;
      end else begin
         next_count = count;
      end
   end

   // Counter state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= `COUNT_RESET;
      end else begin
         count <= next_count;
      end
   end

endmodule // sat_event_counter

// File: tb_phy_status_regs.sv
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, e, g)

module tb_phy_status_regs;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, jabber_detect, negotiation_done_flag;
   logic loopback_enabled, full_duplex, speed_10, link_valid, collision;
   logic false_carrier_event, carrier_valid, invalid_symbol;
   logic hreadyout, hresp, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd, rd2;
   wire logic hready;
   int checks = 0;
   int n_fail = 0;

   // 200 MHz clock; single slave so its ready is the bus ready
   always #2.5 hclk = ~hclk;
   assign hready = hreadyout;

   phy_status_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .jabber_detect(jabber_detect),
      .negotiation_done_flag(negotiation_done_flag),
      .loopback_enabled(loopback_enabled), .full_duplex(full_duplex),
      .speed_10(speed_10), .link_valid(link_valid),
      .false_carrier_event(false_carrier_event),
      .carrier_valid(carrier_valid), .invalid_symbol(invalid_symbol),
      .collision(collision), .irq(irq));

   task check(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task report_and_stop;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Single word transfer; read data lands in rd
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] v);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= v;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   // Two single reads of one register; first lands in rd, second in rd2
   task rd_pair(input logic [31:0] a);
      logic [31:0] first;
      ahb(1'b0, a, 32'h0);
      first = rd;
      ahb(1'b0, a, 32'h0);
      rd2 = rd;
      rd = first;
   endtask

   // One carrier with invalid symbols held over several cycles
   task carrier(input logic err, input logic col);
      @(posedge hclk);
      carrier_valid <= 1'b1;
      collision <= col;
      invalid_symbol <= err;
      repeat (3) @(posedge hclk);
      invalid_symbol <= 1'b0;
      @(posedge hclk);
      carrier_valid <= 1'b0;
      collision <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask

   task fc_burst(input int n);
      @(posedge hclk);
      false_carrier_event <= 1'b1;
      repeat (n) @(posedge hclk);
      false_carrier_event <= 1'b0;
   endtask

   task t_reset;
      ahb(1'b0, 32'h40, 32'h0);
      `CHK("status", 32'h0, rd);
      ahb(1'b0, 32'h50, 32'h0);
      `CHK("fc count", 32'h0, rd);
      ahb(1'b0, 32'h54, 32'h0);
      `CHK("rx count", 32'h0, rd);
      `CHK("resp", 32'h0, {31'h0, hresp});
      `CHK("ready", 32'h1, {31'h0, hreadyout});
   endtask

   // Each source alone; a repeated read must not clear it
   task t_status;
      for (int i = 0; i < 6; i++) begin
         {jabber_detect, negotiation_done_flag, loopback_enabled,
            full_duplex, speed_10, link_valid} <= 6'h01 << i;
         ahb(1'b0, 32'h40, 32'h0);
         `CHK("status bit", 32'h1 << i, rd);
         ahb(1'b0, 32'h40, 32'h0);
         `CHK("status again", 32'h1 << i, rd);
      end
      // Settled link with negotiation done: duplex and speed trusted
      {jabber_detect, negotiation_done_flag, loopback_enabled,
         full_duplex, speed_10, link_valid} <= 6'h17;
      ahb(1'b0, 32'h40, 32'h0);
      `CHK("settled link", 32'h17, rd);
      {jabber_detect, negotiation_done_flag, loopback_enabled,
         full_duplex, speed_10, link_valid} <= 6'h00;
   endtask

   task t_fc;
      ahb(1'b1, 32'h50, 32'hFFFFFFFF);
      fc_burst(3);
      ahb(1'b0, 32'h40, 32'h0);
      `CHK("fc latch", 32'h800, rd & 32'h800);
      rd_pair(32'h50);
      `CHK("fc count", 32'h3, rd);
      `CHK("fc cleared", 32'h0, rd2);
      ahb(1'b0, 32'h40, 32'h0);
      `CHK("fc latch off", 32'h0, rd & 32'h800);
      fc_burst(300);
      rd_pair(32'h50);
      `CHK("fc stuck", 32'hFF, rd);
      `CHK("fc sat clear", 32'h0, rd2);
   endtask

   task t_rx;
      @(posedge hclk);
      invalid_symbol <= 1'b1;
      @(posedge hclk);
      invalid_symbol <= 1'b0;
      carrier(1'b0, 1'b0);
      carrier(1'b1, 1'b1);
      ahb(1'b0, 32'h54, 32'h0);
      `CHK("rx none", 32'h0, rd);
      carrier(1'b1, 1'b0);
      ahb(1'b0, 32'h40, 32'h0);
      `CHK("rx latch", 32'h2000, rd & 32'h2000);
      rd_pair(32'h54);
      `CHK("rx once", 32'h1, rd);
      `CHK("rx cleared", 32'h0, rd2);
      repeat (260) carrier(1'b1, 1'b0);
      ahb(1'b0, 32'h54, 32'h0);
      `CHK("rx stuck", 32'hFF, rd);
      ahb(1'b0, 32'h40, 32'h0);
      `CHK("rx latch off", 32'h0, rd & 32'h2000);
   endtask

   // Raise, clear and mask the false carrier interrupt
   task t_irq;
      // Every source has fired by now: fc, rx error, link and negotiation
      ahb(1'b0, 32'h60, 32'h0);
      `CHK("int sources", 32'hF, rd);
      ahb(1'b1, 32'h60, 32'hF);
      ahb(1'b0, 32'h60, 32'h0);
      `CHK("int cleared", 32'h0, rd);
      ahb(1'b1, 32'h64, 32'h1);
      fc_burst(1);
      #1 `CHK("irq set", 32'h1, {31'h0, irq});
      ahb(1'b1, 32'h60, 32'h1);
      #1 `CHK("irq clear", 32'h0, {31'h0, irq});
      ahb(1'b1, 32'h64, 32'h0);
      fc_burst(1);
      #1 `CHK("irq masked", 32'h0, {31'h0, irq});
      ahb(1'b0, 32'h60, 32'h0);
      `CHK("int status", 32'h1, rd & 32'h1);
      ahb(1'b0, 32'h100, 32'h0);
      `CHK("unmapped", 32'h0, rd);
   endtask

   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, jabber_detect, negotiation_done_flag, loopback_enabled,
         full_duplex, speed_10, link_valid, collision, false_carrier_event,
         carrier_valid, invalid_symbol} = 12'h000;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_status;
      t_fc;
      t_rx;
      t_irq;
      report_and_stop;
   end

   // Whole run needs about 2300 cycles
   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      report_and_stop;
   end
endmodule // tb_phy_status_regs
